// *** interval_source.sv ***
// far-side block publishing a live interval value
`timescale 1ns/1ps
module interval_source (
    // clock
    input wire logic core_clk,
    // value to publish
    input wire logic [22:0] value,
    // live value
    output logic [22:0] ext_interval
);
    always_ff @(posedge core_clk) ext_interval <= value;
endmodule

// *** ohc_pkg.sv ***
// package: constants and carrier types for the operating-hours counter
// Summary of operation
// R1 - while run is high, total time accumulates and remaining time counts down; both readable
// R2 - alarm output goes high once remaining time reaches zero
// R3 - partial reset clears alarm, reloads remaining time, keeps total run time
// R4 - full reset clears alarm, reloads remaining time, zeroes total run time
// R5 - option: alarm also cleared while a reset is high or run is low
// R6 - total run time keeps counting during partial reset while run is high
// R7 - total run time saturates at 99999 hours and stops
// R8 - service interval and total run time start value are preset by configuration
// R9 - remaining, total and interval values are held retentive; here rst_n clears all three, only total can be restored by preset
// R10 - service interval may come from another block's current value
// R11 - service interval may change in parameter mode without reprogramming
// R12 - time advances on a one-cycle minute tick from the system clock while running
package ohc_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned TICK_S = 60;
    localparam logic [31:0] TICK_CYCLES = 32'(CLK_HZ * TICK_S);
    localparam logic [31:0] TICK_RESET = 32'h00000000;
    localparam int unsigned MIN_W = 23;
    // 99999 hours in minutes
    localparam logic [22:0] TOTAL_LIMIT_MIN = 23'h5B8D44;
    localparam logic [22:0] ZERO_MIN = 23'h000000;
    localparam logic [22:0] MIN_STEP = 23'h000001;
    localparam logic ALARM_RESET = 1'b0;

    typedef struct packed {
        logic run;
        logic partial_reset;
        logic full_reset;
    } ctrl_t;

    typedef struct packed {
        logic [22:0] service_interval;
        logic [22:0] tot_start;
        logic tot_preset;
        logic alarm_follows_run;
        logic use_ext_interval;
    } cfg_t;
endpackage

// *** operating_hours_counter.sv ***
// operating-hours counter with service alarm
`timescale 1ns/1ps
module operating_hours_counter #(
    parameter logic [31:0] TICK_CYCLES_P = ohc_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // control from other logic
    input wire ohc_pkg::ctrl_t ctrl,
    // configuration
    input wire ohc_pkg::cfg_t cfg,
    input wire logic [22:0] ext_interval,
    // status
    output logic alarm,
    output logic [22:0] remaining_time,
    output logic [22:0] total_run_time,
    output logic [22:0] service_interval
);
    import ohc_pkg::*;

    // both reset inputs reload the countdown and drop the alarm
    function automatic logic reload_req(input ctrl_t c);
        reload_req = c.partial_reset | c.full_reset;
    endfunction

    // option: alarm held low while run is low
    function automatic logic follow_clear(input ctrl_t c, input cfg_t f);
        follow_clear = f.alarm_follows_run & ~c.run;
    endfunction

    // one counted minute of running time
    function automatic logic count_step(input ctrl_t c, input logic t);
        count_step = c.run & t;
    endfunction

    // time base
    logic [31:0] tick_cnt_q;
    logic [31:0] tick_cnt_d;
    logic tick;
    // interval selection
    logic [22:0] int_src;
    logic [22:0] int_q;
    logic [22:0] int_d;
    // remaining and total minutes
    logic [22:0] rem_q;
    logic [22:0] rem_d;
    logic [22:0] tot_q;
    logic [22:0] tot_d;
    // alarm
    logic alarm_q;
    logic alarm_d;

    // free-running, so a run pause does not hold the partial minute; run only gates which ticks count
    always_comb begin
        tick = (tick_cnt_q == TICK_CYCLES_P - 32'h00000001); // [R12]
        tick_cnt_d = tick ? TICK_RESET : tick_cnt_q + 32'h00000001; // [R12]
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tick_cnt_q <= TICK_RESET;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    // live select: a new source value is taken at the next edge
    always_comb begin
        int_src = cfg.use_ext_interval ? ext_interval : cfg.service_interval; // [R10] [R11]
        int_d = int_src;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            int_q <= ZERO_MIN;
        end else begin
            int_q <= int_d; // [R9]
        end
    end

    // countdown stops at zero; a reload wins over the step
    always_comb begin
        rem_d = rem_q;
        if (count_step(ctrl, tick) && rem_q != ZERO_MIN) begin
            rem_d = rem_q - MIN_STEP; // [R1]
        end
        if (reload_req(ctrl)) begin
            rem_d = int_src; // [R3] [R4]
        end
    end

    // power-on clears; the countdown comes back only through a reload from int_src
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rem_q <= ZERO_MIN;
        end else begin
            rem_q <= rem_d; // [R9]
        end
    end

    // partial reset leaves this counter alone; full reset beats the preset
    always_comb begin
        tot_d = tot_q;
        if (count_step(ctrl, tick) && tot_q < TOTAL_LIMIT_MIN) begin
            tot_d = tot_q + MIN_STEP; // [R1] [R6] [R7]
        end
        if (cfg.tot_preset) begin
            tot_d = cfg.tot_start; // [R8]
        end
        if (ctrl.full_reset) begin
            tot_d = ZERO_MIN; // [R4]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tot_q <= ZERO_MIN;
        end else begin
            tot_q <= tot_d; // [R9]
        end
    end

    // set on zero, then cleared by reloads and last by the run option
    always_comb begin
        alarm_d = alarm_q;
        if (rem_d == ZERO_MIN) begin
            alarm_d = 1'b1; // [R2]
        end
        if (reload_req(ctrl)) begin
            alarm_d = 1'b0; // [R3] [R4]
        end
        if (follow_clear(ctrl, cfg)) begin
            alarm_d = 1'b0; // [R5]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            alarm_q <= ALARM_RESET;
        end else begin
            alarm_q <= alarm_d;
        end
    end

    assign alarm = alarm_q;
    assign remaining_time = rem_q;
    assign total_run_time = tot_q;
    assign service_interval = int_q;

    // checks: sequences shared by the properties below
    // a counted minute with no reload or preset in the way
    sequence s_clean_step;
        count_step(ctrl, tick) && !reload_req(ctrl) && !cfg.tot_preset;
    endsequence

    // run low and no reload requested
    sequence s_idle;
        !ctrl.run && !reload_req(ctrl);
    endsequence

    // the step that takes the countdown from one to zero
    sequence s_last_minute;
        (rem_q == MIN_STEP) ##0 s_clean_step;
    endsequence

    // countdown at zero with nothing clearing the alarm
    sequence s_zero_hold;
        rem_d == ZERO_MIN && !reload_req(ctrl) && !follow_clear(ctrl, cfg);
    endsequence

    // partial reset alone, no minute counted
    sequence s_partial_only;
        ctrl.partial_reset && !ctrl.full_reset && !cfg.tot_preset && !count_step(ctrl, tick);
    endsequence

    // total at its ceiling, nothing reloading it
    sequence s_at_limit;
        tot_q == TOTAL_LIMIT_MIN && !ctrl.full_reset && !cfg.tot_preset;
    endsequence

    // a counted minute below the ceiling
    sequence s_top_minute;
        (tot_q < TOTAL_LIMIT_MIN) ##0 s_clean_step;
    endsequence

    // properties
    chk_total_saturates: assert property (@(posedge core_clk) disable iff (!rst_n) // [R7]
        s_at_limit
        |=> tot_q == TOTAL_LIMIT_MIN)
        else $error("total run time passed limit");

    chk_alarm_at_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [R2]
        s_zero_hold
        |=> alarm_q)
        else $error("alarm not raised at zero");

    chk_partial_keeps: assert property (@(posedge core_clk) disable iff (!rst_n) // [R3]
        s_partial_only
        |=> !alarm_q && tot_q == $past(tot_q))
        else $error("partial reset misbehaved");

    chk_full_clears: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
        ctrl.full_reset
        |=> tot_q == ZERO_MIN && !alarm_q && rem_q == $past(int_src))
        else $error("full reset misbehaved");

    chk_alarm_follows: assert property (@(posedge core_clk) disable iff (!rst_n) // [R5]
        follow_clear(ctrl, cfg)
        |=> !alarm_q)
        else $error("alarm held while run low");

    chk_run_counts: assert property (@(posedge core_clk) disable iff (!rst_n) // [R1]
        s_top_minute
        |=> tot_q == $past(tot_q) + MIN_STEP)
        else $error("total run time did not advance");

    chk_idle_holds: assert property (@(posedge core_clk) disable iff (!rst_n) // [R12]
        s_idle
        |=> rem_q == $past(rem_q))
        else $error("remaining time moved while idle");

    chk_preset_loads: assert property (@(posedge core_clk) disable iff (!rst_n) // [R8]
        cfg.tot_preset && !ctrl.full_reset
        |=> tot_q == $past(cfg.tot_start))
        else $error("preset not loaded");

    chk_remaining_steps: assert property (@(posedge core_clk) disable iff (!rst_n) // [R1]
        (rem_q != ZERO_MIN) ##0 s_clean_step
        |=> rem_q == $past(rem_q) - MIN_STEP)
        else $error("remaining time did not step down");

    chk_remaining_floor: assert property (@(posedge core_clk) disable iff (!rst_n) // [R2]
        rem_q == ZERO_MIN && !reload_req(ctrl)
        |=> rem_q == ZERO_MIN)
        else $error("remaining time left zero without reload");

    chk_last_minute: assert property (@(posedge core_clk) disable iff (!rst_n) // [R2]
        s_last_minute ##0 !follow_clear(ctrl, cfg)
        |=> alarm_q && rem_q == ZERO_MIN)
        else $error("last minute did not raise alarm");

    chk_alarm_needs_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [R2]
        $rose(alarm_q)
        |-> rem_q == ZERO_MIN)
        else $error("alarm rose with time left");

    chk_reload_value: assert property (@(posedge core_clk) disable iff (!rst_n) // [R3]
        reload_req(ctrl)
        |=> rem_q == $past(int_src) && !alarm_q)
        else $error("reload value wrong");

    chk_total_idle: assert property (@(posedge core_clk) disable iff (!rst_n) // [R1]
        s_idle ##0 !cfg.tot_preset
        |=> tot_q == $past(tot_q))
        else $error("total run time moved while idle");

    chk_total_partial: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
        ctrl.partial_reset && !ctrl.full_reset && !cfg.tot_preset && count_step(ctrl, tick) && tot_q < TOTAL_LIMIT_MIN
        |=> tot_q == $past(tot_q) + MIN_STEP)
        else $error("total run time stalled in partial reset");

    chk_interval_ext: assert property (@(posedge core_clk) disable iff (!rst_n) // [R10]
        cfg.use_ext_interval
        |=> int_q == $past(ext_interval))
        else $error("external interval not taken");

    chk_interval_cfg: assert property (@(posedge core_clk) disable iff (!rst_n) // [R11]
        !cfg.use_ext_interval
        |=> int_q == $past(cfg.service_interval))
        else $error("configured interval not taken");

    chk_tick_restart: assert property (@(posedge core_clk) disable iff (!rst_n) // [R12]
        tick
        |=> tick_cnt_q == TICK_RESET)
        else $error("time base did not restart");

    chk_tick_advance: assert property (@(posedge core_clk) disable iff (!rst_n) // [R12]
        !tick
        |=> tick_cnt_q == $past(tick_cnt_q) + 32'h00000001)
        else $error("time base did not advance");

    chk_alarm_holds: assert property (@(posedge core_clk) disable iff (!rst_n) // [R2]
        alarm_q && !reload_req(ctrl) && !follow_clear(ctrl, cfg)
        |=> alarm_q)
        else $error("alarm dropped without a clear");

    chk_preset_beaten: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
        cfg.tot_preset && ctrl.full_reset
        |=> tot_q == ZERO_MIN)
        else $error("preset beat full reset");

    chk_total_cap: assert property (@(posedge core_clk) disable iff (!rst_n) // [R7]
        (tot_q <= TOTAL_LIMIT_MIN) ##0 s_clean_step
        |=> tot_q <= TOTAL_LIMIT_MIN)
        else $error("total run time crossed limit");

    chk_run_low_kept: assert property (@(posedge core_clk) disable iff (!rst_n) // [R5]
        !cfg.alarm_follows_run && alarm_q && !reload_req(ctrl) && !ctrl.run
        |=> alarm_q)
        else $error("alarm dropped with run low, option off");
endmodule

// *** test_operating_hours_counter.sv ***
// bench for the operating-hours counter
`timescale 1ns/1ps
module test_operating_hours_counter;
    import ohc_pkg::*;
    logic core_clk = 0, rst_n = 0, alarm;
    ctrl_t ctrl = '0;
    cfg_t cfg = '0;
    logic [22:0] val = 23'h5, ext, rem, tot, ivl;
    int errors = 0, checks_done = 0;
    always #12.5 core_clk = ~core_clk;
    interval_source src (.core_clk(core_clk), .value(val), .ext_interval(ext));
    // short tick keeps the run small
    operating_hours_counter #(.TICK_CYCLES_P(32'h4)) DUT (.core_clk(core_clk), .rst_n(rst_n), .ctrl(ctrl),
        .cfg(cfg), .ext_interval(ext), .alarm(alarm), .remaining_time(rem), .total_run_time(tot),
        .service_interval(ivl));
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    // bounded wait; outputs read at the edge, before its own updates land
    task automatic wait_alarm();
        for (int i = 0; i < 80 && alarm !== 1'b1; i++) cyc(1);
    endtask
    task automatic full_clear();
        ctrl.full_reset <= 1;
        cyc(1);
        ctrl.full_reset <= 0;
        cyc(1);
    endtask
    task automatic t_count();
        full_clear();
        chk(rem === 23'h3 && tot === 23'h0 && alarm === 0, "full reset");
        ctrl.run <= 1;
        wait_alarm();
        chk(alarm === 1 && rem === 23'h0 && tot === 23'h3, "countdown");
    endtask
    task automatic t_partial();
        ctrl.partial_reset <= 1;
        cyc(9);
        chk(alarm === 0 && rem === 23'h3 && tot > 23'h3, "partial reset");
        ctrl.partial_reset <= 0;
        ctrl.run <= 0;
    endtask
    task automatic t_follow();
        cfg.alarm_follows_run <= 1;
        ctrl.run <= 1;
        wait_alarm();
        chk(alarm === 1, "alarm raised again");
        ctrl.run <= 0;
        cyc(3);
        chk(alarm === 0, "alarm follows run");
    endtask
    task automatic t_ext();
        cfg.use_ext_interval <= 1;
        cyc(2);
        full_clear();
        chk(ivl === 23'h5 && rem === 23'h5 && tot === 23'h0, "external interval");
    endtask
    // preset one minute short of the limit, then overrun it
    task automatic t_sat();
        cfg.tot_start <= TOTAL_LIMIT_MIN - 23'h1;
        cfg.tot_preset <= 1;
        cyc(1);
        cfg.tot_preset <= 0;
        ctrl.run <= 1;
        cyc(24);
        chk(tot === TOTAL_LIMIT_MIN, "saturation");
    endtask
    task automatic print_verdict();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        cfg.service_interval <= 23'h3;
        cyc(2);
        rst_n <= 1;
        cyc(1);
        t_count();
        t_partial();
        t_follow();
        t_ext();
        t_sat();
        print_verdict();
    end
    initial begin
        #30000;
        errors++;
        print_verdict();
    end
endmodule
